// >>> design/flash_key_fsm.v
`include "flash_lock_defs.vh"
`default_nettype none

module flash_key_fsm (
  input wire sys_clk_i,
  input wire rst_i,
  input wire key_wr_i,
  input wire [7:0] key_data_i,
  input wire bad_attempt_i,
  input wire op_done_i,
  output wire [1:0] state_o
);

  reg [1:0] state_reg;
  reg [1:0] state_next;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `LOCK_LOCKED: begin
        if (bad_attempt_i) begin
          state_next = `LOCK_DEAD;
        end else if (key_wr_i) begin
          state_next = (key_data_i == `KEY_FIRST) ? `LOCK_FIRST : `LOCK_DEAD;
        end
      end
      `LOCK_FIRST: begin
        if (bad_attempt_i) begin
          state_next = `LOCK_DEAD;
        end else if (key_wr_i) begin
          state_next = (key_data_i == `KEY_SECOND) ? `LOCK_OPEN : `LOCK_DEAD;
        end
      end
      `LOCK_OPEN: begin
        if (key_wr_i) begin
          state_next = `LOCK_DEAD;
        end else if (op_done_i) begin
          state_next = `LOCK_LOCKED;
        end
      end
      `LOCK_DEAD: begin
        state_next = `LOCK_DEAD;
      end
      default: begin
        state_next = `LOCK_DEAD;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= `LOCK_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

endmodule // flash_key_fsm

`default_nettype wire

// >>> design/flash_lock_defs.vh
// Overview of operation
// - Write-enable bit 0 set sends external-move writes to flash as one byte.
// - Erase-enable plus write-enable makes an external-move write erase the addressed page.
// - Control bits 7 to 2 read zero; writes to them do nothing.
// - Key 0xA5 then 0xF1 unlocks flash writes and erases.
// - After one write or erase completes, operations are disabled again.
// - Wrong or out-of-order key write locks flash until reset.
// - Flash attempt while not unlocked changes nothing and locks until reset.
// - First key other than 0xA5 locks flash until reset.
// - Key register read gives lock state in bits 1 to 0.
`ifndef FLASH_LOCK_DEFS_VH
`define FLASH_LOCK_DEFS_VH

`define CTL_REG_ADDR 8'h8F
`define KEY_REG_ADDR 8'hB7
`define CTL_WEN_BIT 0
`define CTL_EEN_BIT 1
`define CTL_RESET 8'h00
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define LOCK_LOCKED 2'h0
`define LOCK_FIRST 2'h1
`define LOCK_OPEN 2'h2
`define LOCK_DEAD 2'h3
`define RDATA_RESET 8'h00

`endif

// >>> design/flash_write_guard.v
`include "flash_lock_defs.vh"
`default_nettype none

module flash_write_guard #(
  parameter ADDR_W = 16
) (
  input wire sys_clk_i,
  input wire rst_i,
  // special-function register port of the core
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  output reg sfr_rvalid_o,
  // external-move write from the core
  input wire external_move_instruction_wr_i,
  input wire [ADDR_W-1:0] xmove_addr_i,
  input wire [7:0] xmove_data_i,
  // data-memory side, used when flash writes are off
  output reg xram_wr_o,
  output reg [ADDR_W-1:0] xram_addr_o,
  output reg [7:0] xram_data_o,
  // flash array side
  output reg flash_wr_o,
  output reg flash_erase_o,
  output reg [ADDR_W-1:0] flash_addr_o,
  output reg [7:0] flash_data_o,
  input wire flash_done_i,
  // status
  output reg busy_o,
  output reg refused_o,
  output reg program_write_enable_o,
  output reg page_erase_enable_o,
  output reg [1:0] lock_state_o
);

  reg program_write_enable_reg;
  reg page_erase_enable_reg;
  reg busy_reg;
  reg [7:0] rdata_next;
  wire [1:0] lock_state;
  wire ctl_wr;
  wire key_wr;
  wire flash_try;
  wire flash_go;
  wire bad_attempt;
  wire op_done;
  wire busy_drop;
  wire [7:0] ctl_reset;
  wire erase_go;
  wire prog_go;
  wire xram_go;

  // reset image of the control bits comes from the single reset constant
  assign ctl_reset = `CTL_RESET;

  assign ctl_wr = sfr_wr_i && (sfr_addr_i == `CTL_REG_ADDR);
  assign key_wr = sfr_wr_i && (sfr_addr_i == `KEY_REG_ADDR);

  assign flash_try = external_move_instruction_wr_i && program_write_enable_reg && !busy_reg;

  assign flash_go = flash_try && (lock_state == `LOCK_OPEN);

  assign bad_attempt = flash_try && (lock_state != `LOCK_OPEN);

  // a new flash write while one is in flight is dropped; the core is expected to stall
  assign busy_drop = external_move_instruction_wr_i && program_write_enable_reg && busy_reg;

  assign op_done = busy_reg && flash_done_i;

  assign erase_go = flash_go && page_erase_enable_reg;

  assign prog_go = flash_go && !page_erase_enable_reg;

  assign xram_go = external_move_instruction_wr_i && !program_write_enable_reg;

  flash_key_fsm u_key (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .key_wr_i(key_wr),
    .key_data_i(sfr_wdata_i),
    .bad_attempt_i(bad_attempt),
    .op_done_i(op_done),
    .state_o(lock_state)
  );

  // only bits 1 and 0 are stored
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      program_write_enable_reg <= ctl_reset[`CTL_WEN_BIT];
      page_erase_enable_reg <= ctl_reset[`CTL_EEN_BIT];
    end else if (ctl_wr) begin
      program_write_enable_reg <= sfr_wdata_i[`CTL_WEN_BIT];
      page_erase_enable_reg <= sfr_wdata_i[`CTL_EEN_BIT];
    end
  end

  // read data, one cycle after the strobe
  always @* begin
    rdata_next = `RDATA_RESET;
    case (sfr_addr_i)
      `CTL_REG_ADDR: begin
        rdata_next[`CTL_WEN_BIT] = program_write_enable_reg;
        rdata_next[`CTL_EEN_BIT] = page_erase_enable_reg;
      end
      `KEY_REG_ADDR: begin
        rdata_next[1:0] = lock_state;
      end
      default: begin
        rdata_next = `RDATA_RESET;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= `RDATA_RESET;
      sfr_rvalid_o <= 1'b0;
    end else begin
      sfr_rvalid_o <= sfr_rd_i;
      if (sfr_rd_i) begin
        sfr_rdata_o <= rdata_next;
      end
    end
  end

  // busy spans from the issue pulse until the array reports done
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (flash_go) begin
      busy_reg <= 1'b1;
    end else if (op_done) begin
      busy_reg <= 1'b0;
    end
  end

  // strobes are one-cycle pulses; erase and program never fire together
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      flash_wr_o <= 1'b0;
      flash_erase_o <= 1'b0;
    end else begin
      flash_erase_o <= erase_go;
      flash_wr_o <= prog_go;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      refused_o <= 1'b0;
    end else begin
      // the array never sees a refused attempt, only this flag does
      refused_o <= bad_attempt || busy_drop;
    end
  end

  // address and data hold after the pulse so a slow array can sample late
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      flash_addr_o <= {ADDR_W{1'b0}};
      flash_data_o <= 8'h00;
    end else if (flash_go) begin
      flash_addr_o <= xmove_addr_i;
      flash_data_o <= page_erase_enable_reg ? 8'h00 : xmove_data_i;
    end
  end

  // write-enable clear keeps writes in data memory
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      xram_wr_o <= 1'b0;
    end else begin
      xram_wr_o <= xram_go;
    end
  end

  // data-memory payload holds until the next routed write
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      xram_addr_o <= {ADDR_W{1'b0}};
      xram_data_o <= 8'h00;
    end else if (xram_go) begin
      xram_addr_o <= xmove_addr_i;
      xram_data_o <= xmove_data_i;
    end
  end

  // status mirrors, registered so every output is a flop
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      program_write_enable_o <= 1'b0;
      page_erase_enable_o <= 1'b0;
    end else begin
      busy_o <= busy_reg;
      program_write_enable_o <= program_write_enable_reg;
      page_erase_enable_o <= page_erase_enable_reg;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      lock_state_o <= `LOCK_LOCKED;
    end else begin
      lock_state_o <= lock_state;
    end
  end

endmodule // flash_write_guard

`default_nettype wire

// >>> testbench/flash_array_model.sv
`default_nettype none
module flash_array_model #(parameter int DLY = 3) (
  input wire logic sys_clk_i,
  input wire logic start_i,
  output var logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial done_o = 1'b0;
  // array needs a few cycles, so done comes late
  // steady clock throughout
  always @(posedge sys_clk_i) begin
    done_o <= cnt == 1;
    cnt <= start_i ? DLY : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule // flash_array_model
`default_nettype wire

// >>> testbench/flash_write_guard_props.sv
`default_nettype none
module flash_guard_props (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic external_move_instruction_wr_i,
  input wire logic xram_wr_o,
  input wire logic flash_wr_o,
  input wire logic flash_erase_o,
  input wire logic flash_done_i,
  input wire logic busy_o,
  input wire logic refused_o,
  input wire logic program_write_enable_o,
  input wire logic page_erase_enable_o,
  input wire logic [1:0] lock_state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire kw = sfr_wr_i && sfr_addr_i == 8'hB7;
  wire k2 = kw && sfr_wdata_i == 8'hF1;
  wire fop = flash_wr_o | flash_erase_o;
  wire mv = external_move_instruction_wr_i;
  wire [1:0] ls = lock_state_o;
  // status lags the state by one cycle, hence the depth of two
  unlock_pair_a: assert property (ls == 2'h2 && $past(ls) != 2'h2 |-> $past(k2, 2))
    else $error("unlock without key pair");
  dead_stays_a: assert property (ls == 2'h3 |=> ls == 2'h3)
    else $error("dead lock left");
  bad_first_a: assert property (kw && !(sfr_wdata_i inside {8'hA5, 8'hF1}) && ls == 2'h0
    |-> ##2 ls == 2'h3) else $error("bad first key not locked");
  locked_try_a: assert property (mv && program_write_enable_o && ls == 2'h0
    && !$past(sfr_wr_i) |=> refused_o && !fop ##1 ls == 2'h3)
    else $error("locked attempt passed");
  xram_route_a: assert property (mv && !program_write_enable_o && !$past(sfr_wr_i)
    |=> xram_wr_o && !fop) else $error("move not sent to data memory");
  op_unlocked_a: assert property (fop |-> ls == 2'h2 && program_write_enable_o)
    else $error("flash op while locked");
  erase_select_a: assert property (fop |-> flash_erase_o == page_erase_enable_o
    && !(flash_wr_o && flash_erase_o)) else $error("erase select wrong");
  relock_done_a: assert property (flash_done_i && busy_o |-> ##2 ls == 2'h0 && !busy_o)
    else $error("no relock after op");
endmodule // flash_guard_props
bind flash_write_guard flash_guard_props u_flash_guard_props (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i),
  .external_move_instruction_wr_i(external_move_instruction_wr_i),
  .xram_wr_o(xram_wr_o),
  .flash_wr_o(flash_wr_o),
  .flash_erase_o(flash_erase_o),
  .flash_done_i(flash_done_i),
  .busy_o(busy_o),
  .refused_o(refused_o),
  .program_write_enable_o(program_write_enable_o),
  .page_erase_enable_o(page_erase_enable_o),
  .lock_state_o(lock_state_o)
);
`default_nettype wire

// >>> testbench/flash_write_guard_tb_top.sv
`default_nettype none
module flash_write_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, mv = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, md = 8'h00, rdata, fd, xd;
  logic [15:0] ma = 16'h0000, fa, xa;
  logic rv, xw, fw, fe, done, busy, refu, pwe, pee;
  logic [1:0] ls;
  int fail_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  flash_write_guard u_flash_write_guard (.sys_clk_i(clk), .rst_i(rst), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .sfr_rvalid_o(rv),
    .external_move_instruction_wr_i(mv), .xmove_addr_i(ma), .xmove_data_i(md),
    .xram_wr_o(xw), .xram_addr_o(xa), .xram_data_o(xd), .flash_wr_o(fw), .flash_erase_o(fe),
    .flash_addr_o(fa), .flash_data_o(fd), .flash_done_i(done), .busy_o(busy),
    .refused_o(refu), .program_write_enable_o(pwe), .page_erase_enable_o(pee),
    .lock_state_o(ls));
  flash_array_model u_flash_array_model (.sys_clk_i(clk), .start_i(fw | fe), .done_o(done));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // kind 0 register write, 1 register read, 2 external move
  task automatic pulse(int kind, logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a[7:0];
    ma <= a;
    wd <= d;
    md <= d;
    wr <= kind == 0;
    rd <= kind == 1;
    mv <= kind == 2;
    @(posedge clk);
    {wr, rd, mv} <= 3'h0;
    #1;
  endtask
  task automatic rd_chk(string n, logic [7:0] a, logic [7:0] exp);
    pulse(1, {8'h00, a}, 8'h00);
    check(n, {7'h00, rv, rdata}, {8'h01, exp});
  endtask
  task automatic key2(logic [7:0] d1, logic [7:0] d2);
    pulse(0, 16'h00B7, d1);
    pulse(0, 16'h00B7, d2);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1;
    repeat (7) @(posedge clk);
    rst <= 0;
  endtask
  initial begin
    #50us;
    fail_count++;
    report_and_stop();
  end
  initial begin
    do_reset();
    rd_chk("key", 8'hB7, 8'h00);
    pulse(0, 16'h008F, 8'hFE);
    rd_chk("control", 8'h8F, 8'h02);
    pulse(0, 16'h008F, 8'h00);
    pulse(2, 16'h0123, 8'h77);
    check("data move", {xw, fw, xa[7:0]}, 16'h0223);
    check("data move data", {8'h00, xd}, 16'h0077);
    $display("test 1 done");
    pulse(0, 16'h00B7, 8'hA5);
    rd_chk("key", 8'hB7, 8'h01);
    pulse(0, 16'h00B7, 8'hF1);
    rd_chk("key", 8'hB7, 8'h02);
    pulse(0, 16'h008F, 8'h03);
    pulse(2, 16'h1234, 8'h99);
    check("erase", {fe, fw, fa[11:0]}, 16'h2234);
    check("erase data", {8'h00, fd}, 16'h0000);
    pulse(2, 16'h1240, 8'h66);
    check("move while busy", {12'h000, refu, busy, fw, fe}, 16'h000C);
    wait_done();
    rd_chk("key", 8'hB7, 8'h00);
    $display("test 2 done");
    key2(8'hA5, 8'hF1);
    pulse(0, 16'h008F, 8'h01);
    pulse(2, 16'h1234, 8'h5A);
    check("write", {fw, fe, fd}, 16'h025A);
    wait_done();
    pulse(2, 16'h1235, 8'h11);
    check("refused", {refu, fw, fe}, 16'h0004);
    rd_chk("key", 8'hB7, 8'h03);
    key2(8'hA5, 8'hF1);
    rd_chk("key", 8'hB7, 8'h03);
    $display("test 3 done");
    do_reset();
    pulse(0, 16'h00B7, 8'h5C);
    rd_chk("key", 8'hB7, 8'h03);
    do_reset();
    key2(8'hA5, 8'hA5);
    rd_chk("key", 8'hB7, 8'h03);
    do_reset();
    key2(8'hA5, 8'hF1);
    pulse(0, 16'h00B7, 8'hF1);
    rd_chk("key", 8'hB7, 8'h03);
    $display("test 4 done");
    report_and_stop();
  end
endmodule // flash_write_guard_tb_top
`default_nettype wire
